// ==== design/dpia_burst_order.sv ====
// Column order of one burst beat
`timescale 1ns/100ps
module dpia_burst_order
(
   // Burst setup
   input wire logic [2:0] start,
   input wire logic interleave,
   input wire logic chop,
   // Beat and result
   input wire logic [2:0] beat,
   output logic [2:0] col
);
   always_comb
   begin
      if (interleave)
      begin
         col = start ^ beat;
      end
      else if (chop)
      begin
         // Chopped sequential wraps inside the half of eight
         col = {start[2], start[1:0] + beat[1:0]};
      end
      else
      begin
         col = start + beat;
      end
   end
endmodule

// ==== design/dpia_device.sv ====
// DDR3 device command decode, init wait and burst data path
`timescale 1ns/100ps
module dpia_device
#(
   parameter int INIT_CYC = dpia_pkg::INIT_CYC,
   parameter int ROW_W = 2,
   parameter int COLH_W = 2
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Command pins
   input wire logic ck,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [2:0] ba,
   input wire logic [12:0] addr,
   input wire logic mem_rst_n,
   // Low byte lane
   input wire logic [7:0] low_lane_data_i,
   output logic [7:0] low_lane_data_o,
   output logic low_lane_data_oe,
   input wire logic low_lane_strobe_pair_t_i,
   input wire logic low_lane_strobe_pair_c_i,
   output logic low_lane_strobe_pair_t_o,
   output logic low_lane_strobe_pair_c_o,
   output logic low_lane_strobe_pair_oe,
   // High byte lane
   input wire logic [7:0] high_lane_data_i,
   output logic [7:0] high_lane_data_o,
   output logic high_lane_data_oe,
   input wire logic high_lane_strobe_pair_t_i,
   input wire logic high_lane_strobe_pair_c_i,
   output logic high_lane_strobe_pair_t_o,
   output logic high_lane_strobe_pair_c_o,
   output logic high_lane_strobe_pair_oe,
   // Status
   output logic ready
);
   localparam int PW = 43;
   localparam int CNT_W = $clog2(INIT_CYC + 1);
   localparam int MA_W = dpia_pkg::BA_W + ROW_W + COLH_W + 3;

   typedef struct packed {
      dpia_pkg::dpia_state_t st;
      logic [CNT_W-1:0] cnt;
      logic [PW-1:0] s1;
      logic [PW-1:0] s2;
      logic ck_q;
      logic dqsl_q;
      logic dqsu_q;
      logic [dpia_pkg::NUM_BANKS-1:0] open;
      logic [dpia_pkg::NUM_BANKS-1:0][12:0] rows;
      logic [3:0][12:0] mr;
      logic rd_act;
      logic wr_act;
      logic ap;
      logic chop;
      logic [2:0] bank;
      logic [dpia_pkg::COL_W-1:0] col;
      logic [3:0] beat;
      logic [7:0] dqh_hold;
      logic mwe;
      logic [MA_W-1:0] maddr;
      logic [15:0] mdata;
      logic [7:0] dql_o;
      logic [7:0] dqh_o;
      logic dq_oe;
      logic dqs_t;
      logic dqs_c;
      logic dqs_oe;
      logic ready;
   } dpia_regs_t;

   dpia_regs_t r_r;
   dpia_regs_t r_nxt;
   logic [15:0] mem [0:(1<<MA_W)-1];
   logic ck_s, cke_s, rstp_s, dqsl_t_s, dqsl_c_s, dqsu_t_s, dqsu_c_s;
   logic [3:0] cmd_s;
   logic [2:0] ba_s;
   logic [12:0] a_s;
   logic [7:0] dql_s, dqh_s;
   logic ck_rise, ck_edge, lvl_l, lvl_u, dqsl_edge, dqsu_edge, cmd_ok;
   logic [3:0] len;
   logic [2:0] ord;
   logic [MA_W-1:0] cur_addr;
   logic [15:0] mem_q;

   dpia_burst_order u_order
   (
      .start(r_r.col[2:0]),
      .interleave(r_r.mr[0][dpia_pkg::BT_BIT]),
      .chop(r_r.chop),
      .beat(r_r.beat[2:0]),
      .col(ord)
   );

   assign len = r_r.chop ? dpia_pkg::BURST_CHOP : dpia_pkg::BURST_FULL;
   assign cur_addr = {r_r.bank, r_r.rows[r_r.bank][ROW_W-1:0],
      r_r.col[COLH_W+2:3], ord};
   assign mem_q = mem[cur_addr];

   always_comb
   begin
      r_nxt = r_r;
      // Every pin is asynchronous to clk, so all pass two stages
      r_nxt.s1 = {ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, mem_rst_n,
         low_lane_strobe_pair_t_i, low_lane_strobe_pair_c_i,
         high_lane_strobe_pair_t_i, high_lane_strobe_pair_c_i,
         low_lane_data_i, high_lane_data_i};
      r_nxt.s2 = r_r.s1;
      {ck_s, cke_s, cmd_s, ba_s, a_s, rstp_s, dqsl_t_s, dqsl_c_s, dqsu_t_s,
         dqsu_c_s, dql_s, dqh_s} = r_r.s2;
      ck_rise = ck_s & ~r_r.ck_q;
      ck_edge = ck_s ^ r_r.ck_q;
      // A strobe pair whose halves agree is not a valid level
      lvl_l = (dqsl_t_s != dqsl_c_s) ? dqsl_t_s : r_r.dqsl_q;
      lvl_u = (dqsu_t_s != dqsu_c_s) ? dqsu_t_s : r_r.dqsu_q;
      dqsl_edge = lvl_l ^ r_r.dqsl_q;
      dqsu_edge = lvl_u ^ r_r.dqsu_q;
      r_nxt.ck_q = ck_s;
      r_nxt.dqsl_q = lvl_l;
      r_nxt.dqsu_q = lvl_u;
      r_nxt.mwe = 1'b0;
      r_nxt.ready = (r_r.st == dpia_pkg::ST_RUN);
      cmd_ok = ck_rise & cke_s;
      if (dqsu_edge)
      begin
         r_nxt.dqh_hold = dqh_s;
      end
      if (!rstp_s)
      begin
         r_nxt.st = dpia_pkg::ST_RESET;
         r_nxt.open = '0;
         r_nxt.rd_act = 1'b0;
         r_nxt.wr_act = 1'b0;
         r_nxt.dq_oe = 1'b0;
         r_nxt.dqs_oe = 1'b0;
      end
      else
      begin
         unique case (r_r.st)
            dpia_pkg::ST_RESET:
            begin
               r_nxt.st = dpia_pkg::ST_INIT;
               r_nxt.cnt = CNT_W'(INIT_CYC - 1);
            end
            dpia_pkg::ST_INIT:
            begin
               // Timed on clk alone; the external clock may still be off
               if (r_r.cnt == '0)
               begin
                  r_nxt.st = dpia_pkg::ST_WAIT;
               end
               else
               begin
                  r_nxt.cnt = r_r.cnt - 1'b1;
               end
            end
            dpia_pkg::ST_WAIT:
            begin
               if (cmd_ok)
               begin
                  r_nxt.st = dpia_pkg::ST_RUN;
               end
            end
            dpia_pkg::ST_RUN:
            begin
               if (r_r.rd_act && ck_edge)
               begin
                  if (r_r.beat == len)
                  begin
                     r_nxt.rd_act = 1'b0;
                     r_nxt.dq_oe = 1'b0;
                     r_nxt.dqs_oe = 1'b0;
                     if (r_r.ap)
                     begin
                        r_nxt.open[r_r.bank] = 1'b0;
                     end
                  end
                  else
                  begin
                     // One beat per clock edge, strobe edge-aligned
                     r_nxt.dql_o = mem_q[7:0];
                     r_nxt.dqh_o = mem_q[15:8];
                     r_nxt.dqs_t = ck_s;
                     r_nxt.dqs_c = ~ck_s;
                     r_nxt.dq_oe = 1'b1;
                     r_nxt.dqs_oe = 1'b1;
                     r_nxt.beat = r_r.beat + 4'h1;
                  end
               end
               if (r_r.wr_act && dqsl_edge)
               begin
                  // Upper byte taken from its own strobe edge
                  r_nxt.mwe = 1'b1;
                  r_nxt.maddr = cur_addr;
                  r_nxt.mdata = {dqsu_edge ? dqh_s : r_r.dqh_hold, dql_s};
                  r_nxt.beat = r_r.beat + 4'h1;
                  if (r_r.beat == len - 4'h1)
                  begin
                     r_nxt.wr_act = 1'b0;
                     if (r_r.ap)
                     begin
                        r_nxt.open[r_r.bank] = 1'b0;
                     end
                  end
               end
               if (cmd_ok)
               begin
                  unique case (cmd_s)
                     dpia_pkg::CMD_ACT:
                     begin
                        r_nxt.open[ba_s] = 1'b1;
                        r_nxt.rows[ba_s] = a_s;
                     end
                     dpia_pkg::CMD_PRE:
                     begin
                        if (a_s[dpia_pkg::AP_BIT])
                        begin
                           r_nxt.open = '0;
                        end
                        else
                        begin
                           r_nxt.open[ba_s] = 1'b0;
                        end
                     end
                     dpia_pkg::CMD_MRS:
                     begin
                        r_nxt.mr[ba_s[1:0]] = a_s;
                     end
                     dpia_pkg::CMD_RD, dpia_pkg::CMD_WR:
                     begin
                        // Closed bank or busy path: command dropped
                        if (r_r.open[ba_s] && !r_r.rd_act && !r_r.wr_act)
                        begin
                           r_nxt.rd_act = (cmd_s == dpia_pkg::CMD_RD);
                           r_nxt.wr_act = (cmd_s == dpia_pkg::CMD_WR);
                           r_nxt.bank = ba_s;
                           r_nxt.col = a_s[dpia_pkg::COL_W-1:0];
                           r_nxt.ap = a_s[dpia_pkg::AP_BIT];
                           r_nxt.chop = (r_r.mr[0][1:0] == dpia_pkg::BL_FIXED4) ||
                              ((r_r.mr[0][1:0] == dpia_pkg::BL_OTF) &&
                              !a_s[dpia_pkg::BC_BIT]);
                           r_nxt.beat = 4'h0;
                        end
                     end
                     default:
                     begin
                     end
                  endcase
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         r_r <= '0;
         r_r.st <= dpia_pkg::ST_RESET;
      end
      else
      begin
         r_r <= r_nxt;
      end
   end

   // Array kept outside the state record; no reset needed
   always_ff @(posedge clk)
   begin
      if (r_r.mwe)
      begin
         mem[r_r.maddr] <= r_r.mdata;
      end
   end

   assign low_lane_data_o = r_r.dql_o;
   assign high_lane_data_o = r_r.dqh_o;
   assign low_lane_data_oe = r_r.dq_oe;
   assign high_lane_data_oe = r_r.dq_oe;
   assign low_lane_strobe_pair_t_o = r_r.dqs_t;
   assign low_lane_strobe_pair_c_o = r_r.dqs_c;
   assign low_lane_strobe_pair_oe = r_r.dqs_oe;
   assign high_lane_strobe_pair_t_o = r_r.dqs_t;
   assign high_lane_strobe_pair_c_o = r_r.dqs_c;
   assign high_lane_strobe_pair_oe = r_r.dqs_oe;
   assign ready = r_r.ready;

   a_init_count: assert property (@(posedge clk) disable iff (!nrst)
      (r_r.st == dpia_pkg::ST_INIT && r_r.cnt != '0 && rstp_s)
      |=> (r_r.st == dpia_pkg::ST_INIT && r_r.cnt == $past(r_r.cnt) - 1'b1))
      else $error("init count did not step");
   a_init_exit: assert property (@(posedge clk) disable iff (!nrst)
      (r_r.st == dpia_pkg::ST_INIT && r_r.cnt == '0 && rstp_s)
      |=> r_r.st == dpia_pkg::ST_WAIT)
      else $error("init did not end");
   a_act_row: assert property (@(posedge clk) disable iff (!nrst)
      (r_r.st == dpia_pkg::ST_RUN && rstp_s && cmd_ok && cmd_s == dpia_pkg::CMD_ACT)
      |=> (r_r.open[$past(ba_s)] && r_r.rows[$past(ba_s)] == $past(a_s)))
      else $error("activate did not open row");
   a_read_owner: assert property (@(posedge clk) disable iff (!nrst)
      r_r.dq_oe |-> (r_r.dqs_oe && r_r.rd_act && !r_r.wr_act))
      else $error("data driven without read strobe");
   a_strobe_diff: assert property (@(posedge clk) disable iff (!nrst)
      r_r.dqs_oe |-> (r_r.dqs_c == ~r_r.dqs_t))
      else $error("strobe pair not complementary");
   a_beat_step: assert property (@(posedge clk) disable iff (!nrst)
      (r_r.st == dpia_pkg::ST_RUN && rstp_s && r_r.rd_act && ck_edge && r_r.beat != len)
      |=> (r_r.beat == $past(r_r.beat) + 4'h1 && r_r.dq_oe && r_r.dqs_t == $past(ck_s)))
      else $error("read beat missed a clock edge");
   a_beat_max: assert property (@(posedge clk) disable iff (!nrst)
      (r_r.rd_act || r_r.wr_act) |-> r_r.beat <= len)
      else $error("burst ran past its length");
   a_chop_otf: assert property (@(posedge clk) disable iff (!nrst)
      (r_r.st == dpia_pkg::ST_RUN && rstp_s && cmd_ok && cmd_s == dpia_pkg::CMD_RD &&
      r_r.mr[0][1:0] == dpia_pkg::BL_OTF && r_r.open[ba_s] && !r_r.rd_act && !r_r.wr_act)
      |=> (r_r.rd_act && r_r.chop == !$past(a_s[dpia_pkg::BC_BIT])))
      else $error("chop select wrong");
   a_auto_pre: assert property (@(posedge clk) disable iff (!nrst)
      (r_r.st == dpia_pkg::ST_RUN && rstp_s && r_r.rd_act && ck_edge && r_r.beat == len &&
      r_r.ap && !(cmd_ok && cmd_s == dpia_pkg::CMD_ACT))
      |=> (!r_r.open[$past(r_r.bank)] && !r_r.dq_oe))
      else $error("auto precharge did not close bank");
   a_write_take: assert property (@(posedge clk) disable iff (!nrst)
      (r_r.st == dpia_pkg::ST_RUN && rstp_s && r_r.wr_act && dqsl_edge)
      |=> (r_r.mwe && r_r.mdata[7:0] == $past(dql_s)))
      else $error("write beat not stored");
endmodule

// ==== design/dpia_pkg.sv ====
// Constants and types of the DDR3 device access and init block
package dpia_pkg;
   localparam int CLK_PERIOD_NS = 50;
   localparam int INIT_TIME_NS = 500000;
   localparam int INIT_CYC = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int NUM_BANKS = 8;
   localparam int BA_W = 3;
   localparam int ADDR_W = 13;
   localparam int COL_W = 10;
   localparam int LANE_W = 8;
   localparam int AP_BIT = 10;
   localparam int BC_BIT = 12;
   localparam int BT_BIT = 3;
   localparam logic [3:0] BURST_FULL = 4'h8;
   localparam logic [3:0] BURST_CHOP = 4'h4;
   localparam logic [1:0] BL_FIXED8 = 2'h0;
   localparam logic [1:0] BL_OTF = 2'h1;
   localparam logic [1:0] BL_FIXED4 = 2'h2;
   localparam logic [3:0] CMD_MRS = 4'h0;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_WR = 4'h4;
   localparam logic [3:0] CMD_RD = 4'h5;
   localparam logic [3:0] CMD_ZQC = 4'h6;
   localparam logic [3:0] CMD_NOP = 4'h7;
   typedef enum logic [3:0] {
      ST_RESET = 4'h1,
      ST_INIT = 4'h2,
      ST_WAIT = 4'h4,
      ST_RUN = 4'h8
   } dpia_state_t;
endpackage

// ==== verification/dpia_ctrl_model.sv ====
// Memory controller model driving the device command, clock and write pins
`timescale 1ns/100ps
module dpia_ctrl_model
#(
   parameter int RST_HOLD_NS = 200000,
   parameter int INIT_WAIT_NS = 1000
)
(
   // Command pins
   output logic ck,
   output logic cke,
   output logic [3:0] cmd,
   output logic [2:0] ba,
   output logic [12:0] addr,
   output logic mem_rst_n,
   // Write data and strobe of both lanes
   output logic [15:0] dq,
   output logic dqs_t,
   output logic dqs_c
);
   logic ck_run;

   initial
   begin
      ck = 1'b0;
      ck_run = 1'b0;
      cke = 1'b0;
      mem_rst_n = 1'b0;
      cmd = dpia_pkg::CMD_NOP;
      ba = 3'h0;
      addr = 13'h0000;
      dq = 16'h0000;
      dqs_t = 1'b0;
      dqs_c = 1'b0;
   end

   // Clock stands still until the init wait is over
   always #200 if (ck_run) ck = ~ck;

   task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a);
      @(negedge ck);
      cmd = c;
      ba = b;
      addr = a;
      @(negedge ck);
      cmd = dpia_pkg::CMD_NOP;
   endtask

   task automatic power_up(input logic [12:0] mr0);
      ck_run = 1'b0;
      mem_rst_n = 1'b0;
      cke = 1'b0;
      #(RST_HOLD_NS);
      mem_rst_n = 1'b1;
      #(INIT_WAIT_NS);
      ck_run = 1'b1;
      repeat (6) @(posedge ck);
      @(negedge ck);
      cke = 1'b1;
      repeat (5) @(posedge ck);
      issue(dpia_pkg::CMD_MRS, 3'h2, 13'h0000);
      issue(dpia_pkg::CMD_MRS, 3'h3, 13'h0000);
      issue(dpia_pkg::CMD_MRS, 3'h1, 13'h0000);
      issue(dpia_pkg::CMD_MRS, 3'h0, mr0 | 13'h0100);
      issue(dpia_pkg::CMD_ZQC, 3'h0, 13'h0400);
      repeat (8) @(posedge ck);
   endtask

   // Data changes midway between strobe edges
   task automatic write_beats(input logic [15:0] d [8], input int n);
      dqs_t = 1'b0;
      dqs_c = 1'b1;
      for (int i = 0; i < n; i++)
      begin
         dq = d[i];
         #100;
         dqs_t = ~dqs_t;
         dqs_c = ~dqs_t;
         #100;
      end
      dqs_c = dqs_t;
      dq = ~dq;
   endtask
endmodule

// ==== verification/dpia_device_tb.sv ====
// Self-checking bench of the device init wait and burst data path
`timescale 1ns/100ps
module dpia_device_tb;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   int n_fail = 0;
   int check_count = 0;
   logic [31:0] seed = 32'h44FC76B7;
   logic ck, cke, mem_rst_n, c_t, c_c, ready;
   logic l_oe, h_oe, l_so, h_so, l_st, l_sc, h_st, h_sc;
   logic oe_q = 1'b0;
   logic st_q = 1'b0;
   logic [3:0] cmd;
   logic [2:0] ba;
   logic [12:0] addr;
   logic [15:0] c_dq;
   logic [7:0] l_do, h_do;
   logic [15:0] mem_m [8][8];
   logic [15:0] beats [$];

   always #25 clk = ~clk;

   dpia_ctrl_model #(.RST_HOLD_NS(200000), .INIT_WAIT_NS(20 * 50)) CTRL (
      .ck(ck), .cke(cke), .cmd(cmd), .ba(ba), .addr(addr), .mem_rst_n(mem_rst_n),
      .dq(c_dq), .dqs_t(c_t), .dqs_c(c_c));

   dpia_device #(.INIT_CYC(20)) DUT (
      .clk(clk), .nrst(nrst), .ck(ck), .cke(cke),
      .cs_n(cmd[3]), .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]),
      .ba(ba), .addr(addr), .mem_rst_n(mem_rst_n),
      .low_lane_data_i(l_oe ? l_do : c_dq[7:0]), .low_lane_data_o(l_do),
      .low_lane_data_oe(l_oe), .low_lane_strobe_pair_t_i(l_so ? l_st : c_t),
      .low_lane_strobe_pair_c_i(l_so ? l_sc : c_c), .low_lane_strobe_pair_t_o(l_st),
      .low_lane_strobe_pair_c_o(l_sc), .low_lane_strobe_pair_oe(l_so),
      .high_lane_data_i(h_oe ? h_do : c_dq[15:8]), .high_lane_data_o(h_do),
      .high_lane_data_oe(h_oe), .high_lane_strobe_pair_t_i(h_so ? h_st : c_t),
      .high_lane_strobe_pair_c_i(h_so ? h_sc : c_c), .high_lane_strobe_pair_t_o(h_st),
      .high_lane_strobe_pair_c_o(h_sc), .high_lane_strobe_pair_oe(h_so),
      .ready(ready));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [2:0] col_of(input logic [2:0] s, input logic [2:0] i,
                                         input logic il, input logic ch);
      logic [2:0] sq;
      sq = s + i;
      if (il)
         return s ^ i;
      if (ch)
         return {s[2], sq[1:0]};
      return sq;
   endfunction

   task automatic check(input logic ok, input string m);
      check_count++;
      if (ok !== 1'b1)
      begin
         n_fail++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // A beat is a new strobe level while the device drives
   always @(negedge clk)
   begin
      if (l_oe === 1'b1 && (oe_q !== 1'b1 || l_st !== st_q))
      begin
         beats.push_back({h_do, l_do});
         check(l_sc === ~l_st && h_st === l_st && h_sc === l_sc, "strobe pair");
         check(h_oe === 1'b1 && l_so === 1'b1 && h_so === 1'b1, "lane drive");
      end
      oe_q <= l_oe;
      st_q <= l_st;
   end

   task automatic wr(input logic [2:0] b);
      logic [15:0] d [8];
      for (int i = 0; i < 8; i++)
      begin
         d[i] = 16'(rnd());
         mem_m[b][i] = d[i];
      end
      CTRL.issue(dpia_pkg::CMD_WR, b, 13'h1000);
      CTRL.write_beats(d, 8);
      $display("write test bank %0d done", b);
   endtask

   task automatic rd(input logic [2:0] b, input logic [12:0] a, input int n, input logic il);
      int k;
      beats.delete();
      CTRL.issue(dpia_pkg::CMD_RD, b, a);
      for (k = 0; k < 80 && (k < 40 || l_oe !== 1'b0); k++)
         @(posedge clk);
      if (k == 80)
      begin
         check(1'b0, "read burst never ended");
         final_report();
      end
      check(beats.size() == n, "beat count");
      for (int i = 0; i < n && i < beats.size(); i++)
         check(beats[i] === mem_m[b][col_of(a[2:0], 3'(i), il, n == 4)], "read data");
      $display("read test bank %0d start %0d done", b, a[2:0]);
   endtask

   initial
   begin
      logic [12:0] a;
      logic il;
      repeat (8) @(posedge clk);
      #5 nrst = 1'b1;
      fork
         CTRL.power_up({11'h000, dpia_pkg::BL_OTF});
         begin
            #201500;
            check(ready === 1'b0, "ready before clock enable");
         end
      join
      check(ready === 1'b1, "ready after init");
      $display("init test done");
      CTRL.issue(dpia_pkg::CMD_ACT, 3'h0, 13'h0001);
      CTRL.issue(dpia_pkg::CMD_ACT, 3'h5, 13'h0001);
      wr(3'h0);
      wr(3'h5);
      rd(3'h5, 13'h1000, 8, 1'b0);
      for (int t = 0; t < 8; t++)
      begin
         il = t[0];
         a = {t[1], 9'h000, 3'(rnd())};
         CTRL.issue(dpia_pkg::CMD_MRS, 3'h0, {9'h000, il, 1'b0, dpia_pkg::BL_OTF});
         rd(3'h0, a, t[1] ? 8 : 4, il);
      end
      CTRL.issue(dpia_pkg::CMD_MRS, 3'h0, {11'h000, dpia_pkg::BL_FIXED4});
      rd(3'h0, 13'h1003, 4, 1'b0);
      CTRL.issue(dpia_pkg::CMD_MRS, 3'h0, {11'h000, dpia_pkg::BL_FIXED8});
      rd(3'h5, 13'h0006, 8, 1'b0);
      rd(3'h3, 13'h1000, 0, 1'b0);
      rd(3'h0, 13'h1402, 8, 1'b0);
      rd(3'h0, 13'h1000, 0, 1'b0);
      CTRL.power_up({11'h000, dpia_pkg::BL_OTF});
      rd(3'h5, 13'h1000, 0, 1'b0);
      final_report();
   end
endmodule
